//--- design/btsd_core.v
// bit test and skip decode and execute stage
`timescale 1ns/100ps
`include "btsd_defs.vh"
module btsd_core (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire [11:0] fetch_word_i,
    input  wire        fetch_valid_i,
    input  wire        wr_en_i,
    input  wire [4:0]  wr_addr_i,
    input  wire [7:0]  wr_data_i,
    output reg  [11:0] exec_word_o,
    output reg         exec_valid_o,
    output reg         skip_o,
    output reg         nop_cycle_o,
    output wire        flags_we_o,
    output wire [4:0]  rd_addr_o
);
    // instruction kinds and discard-slot states
    localparam [1:0] KIND_NONE = `BTSD_KIND_NONE;
    localparam [1:0] KIND_CLR  = `BTSD_KIND_CLR;
    localparam [1:0] KIND_SET  = `BTSD_KIND_SET;
    localparam [0:0] ST_RUN    = `BTSD_ST_RUN;
    localparam [0:0] ST_NOP    = `BTSD_ST_NOP;

    // opcode field of an instruction word
    function [3:0] opc_of;
        input [11:0] w;
        begin
            opc_of = w[`BTSD_OPC_HI:`BTSD_OPC_LO];
        end
    endfunction

    // file register select field
    function [4:0] reg_of;
        input [11:0] w;
        begin
            reg_of = w[`BTSD_REG_HI:`BTSD_REG_LO];
        end
    endfunction

    // bit position field
    function [2:0] bit_of;
        input [11:0] w;
        begin
            bit_of = w[`BTSD_BIT_HI:`BTSD_BIT_LO];
        end
    endfunction

    // which of the two skip tests a word asks for
    function [1:0] dec_kind;
        input [11:0] w;
        begin
            if (opc_of(w) == `BTSD_OPC_SKS) begin
                dec_kind = KIND_SET;
            end else if (opc_of(w) == `BTSD_OPC_SKC) begin
                dec_kind = KIND_CLR;
            end else begin
                dec_kind = KIND_NONE;
            end
        end
    endfunction

    // skip decision from the decoded kind and the tested bit
    function skip_wanted;
        input [1:0] kind;
        input       bit_val;
        begin
            case (kind)
                KIND_SET: begin
                    skip_wanted = bit_val;
                end
                KIND_CLR: begin
                    skip_wanted = !bit_val;
                end
                default: begin
                    skip_wanted = 1'b0;
                end
            endcase
        end
    endfunction

    // fetch stage registers and next values
    reg  [11:0] cur_r;
    reg  [11:0] cur_nxt;
    reg         cur_v_r;
    reg         cur_v_nxt;
    reg  [2:0]  bsel_r;
    reg  [2:0]  bsel_nxt;
    reg  [1:0]  kind_r;
    reg  [1:0]  kind_nxt;

    // execute stage registers and next values
    reg         st_r;
    reg         st_nxt;
    reg  [11:0] exec_word_nxt;
    reg         exec_valid_nxt;
    reg         skip_nxt;
    reg         nop_cycle_nxt;

    // read data and skip decision
    wire [7:0]  rdata;
    wire [7:0]  bit_hit;
    wire        bitval;
    wire        slot_open;
    wire        test_hit;
    wire        take;

    // file read address leads the decoded fields by one edge
    assign rd_addr_o  = reg_of(fetch_word_i);
    // neither test writes status flags
    assign flags_we_o = 1'b0;

    // a write and a read of one register in one cycle return the old value
    btsd_file_ram u_ram (
        .clk_i   (clk_i),
        .raddr_i (rd_addr_o),
        .we_i    (wr_en_i),
        .waddr_i (wr_addr_i),
        .wdata_i (wr_data_i),
        .rdata_o (rdata)
    );

    // one-hot pick of the tested bit from the read data
    genvar gi;
    generate
        for (gi = 0; gi < `BTSD_DATA_W; gi = gi + 1) begin : g_bit
            localparam [2:0] POS = gi;
            assign bit_hit[gi] = (bsel_r == POS) && rdata[gi];
        end
    endgenerate

    // tested bit of the selected register
    assign bitval    = |bit_hit;
    // a word in the discard slot or an empty fetch never takes
    assign slot_open = cur_v_r && (st_r == ST_RUN);
    assign test_hit  = skip_wanted(kind_r, bitval);
    assign take      = slot_open && test_hit;

    // fetch stage: the next word is held while this one executes
    always @* begin
        cur_nxt   = fetch_word_i;
        cur_v_nxt = fetch_valid_i;
        bsel_nxt  = bit_of(fetch_word_i);
        kind_nxt  = dec_kind(fetch_word_i);
    end

    // discard-slot sequencer: one extra cycle per taken skip
    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN: begin
                if (take) begin
                    st_nxt = ST_NOP;
                end
            end
            ST_NOP: begin
                st_nxt = ST_RUN;
            end
            default: begin
                st_nxt = ST_RUN;
            end
        endcase
    end

    // execute stage: the held word, or an inert slot after a skip
    always @* begin
        exec_word_nxt  = cur_r;
        exec_valid_nxt = cur_v_r;
        nop_cycle_nxt  = 1'b0;
        skip_nxt       = take;
        case (st_r)
            ST_NOP: begin
                // the word fetched under a taken skip is dropped here
                exec_word_nxt  = `BTSD_NOP_WORD;
                exec_valid_nxt = 1'b0;
                nop_cycle_nxt  = 1'b1;
            end
            default: begin
                nop_cycle_nxt  = 1'b0;
            end
        endcase
    end

    // fetch stage registers
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_r   <= `BTSD_NOP_WORD;
            cur_v_r <= 1'b0;
            bsel_r  <= `BTSD_BSEL_RST;
            kind_r  <= KIND_NONE;
        end else begin
            cur_r   <= cur_nxt;
            cur_v_r <= cur_v_nxt;
            bsel_r  <= bsel_nxt;
            kind_r  <= kind_nxt;
        end
    end

    // execute stage registers drive the outputs directly
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r         <= ST_RUN;
            exec_word_o  <= `BTSD_NOP_WORD;
            exec_valid_o <= 1'b0;
            skip_o       <= 1'b0;
            nop_cycle_o  <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            exec_word_o  <= exec_word_nxt;
            exec_valid_o <= exec_valid_nxt;
            skip_o       <= skip_nxt;
            nop_cycle_o  <= nop_cycle_nxt;
        end
    end
endmodule

//--- design/btsd_defs.vh
// constants for the bit test and skip decoder
`ifndef BTSD_DEFS_VH
`define BTSD_DEFS_VH
`define BTSD_IW_W        12
`define BTSD_OPC_HI      11
`define BTSD_OPC_LO      8
`define BTSD_BIT_HI      7
`define BTSD_BIT_LO      5
`define BTSD_REG_HI      4
`define BTSD_REG_LO      0
`define BTSD_OPC_SKC     4'h6
`define BTSD_OPC_SKS     4'h7
`define BTSD_NOP_WORD    12'h000
`define BTSD_ST_RUN      1'b0
`define BTSD_ST_NOP      1'b1
`define BTSD_NREGS       32
`define BTSD_DATA_W      8
`define BTSD_KIND_NONE   2'h0
`define BTSD_KIND_CLR    2'h1
`define BTSD_KIND_SET    2'h2
`define BTSD_BSEL_RST    3'h0
`endif

//--- design/btsd_file_ram.v
// 32 x 8 file register memory with registered read data
`timescale 1ns/100ps
`include "btsd_defs.vh"
module btsd_file_ram (
    input  wire       clk_i,
    input  wire [4:0] raddr_i,
    input  wire       we_i,
    input  wire [4:0] waddr_i,
    input  wire [7:0] wdata_i,
    output reg  [7:0] rdata_o
);
    reg [7:0] mem [0:`BTSD_NREGS-1];
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

//--- sim/btsd_props.sv
// checker for the skip core
`timescale 1ns/100ps
module btsd_props (
    input        clk_i,
    input        nrst_i,
    input [11:0] fetch_word_i,
    input [11:0] exec_word_o,
    input        exec_valid_o,
    input        skip_o,
    input        nop_cycle_o,
    input        flags_we_o,
    input [4:0]  rd_addr_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence nop_slot;
        nop_cycle_o && exec_word_o == 12'h000;
    endsequence
    skip_nop_a: assert property (skip_o |=> nop_slot) else $error("no nop");
    nop_src_a: assert property (nop_cycle_o |-> $past(skip_o)) else $error("stray");
    nop_once_a: assert property (nop_cycle_o |=> !nop_cycle_o) else $error("twice");
    skip_op_a: assert property (skip_o |-> exec_word_o[11:9] == 3'h3) else $error("op");
    prefetch_hold_a:
        assert property (!skip_o |=> exec_word_o == $past(fetch_word_i, 2)) else $error("lost");
    no_flags_a: assert property (!flags_we_o) else $error("flags");
    reg_sel_a: assert property (rd_addr_o == fetch_word_i[4:0]) else $error("sel");
    nop_invalid_a: assert property (nop_cycle_o |-> !exec_valid_o) else $error("valid");
    skip_gap_a: assert property (skip_o |=> !skip_o) else $error("slot took");
endmodule
bind btsd_core btsd_props chk_u (
    .clk_i        (clk_i),
    .nrst_i       (nrst_i),
    .fetch_word_i (fetch_word_i),
    .exec_word_o  (exec_word_o),
    .exec_valid_o (exec_valid_o),
    .skip_o       (skip_o),
    .nop_cycle_o  (nop_cycle_o),
    .flags_we_o   (flags_we_o),
    .rd_addr_o    (rd_addr_o)
);

//--- sim/bit_test_skip_decode_tb.sv
// skip core bench
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t mismatch", $time); end end
module bit_test_skip_decode_tb;
    logic        clk_i = 0, nrst_i = 0, fetch_valid_i = 1, wr_en_i = 0;
    logic        exec_valid_o, skip_o, nop_cycle_o, flags_we_o;
    logic [11:0] fetch_word_i = 0, exec_word_o;
    logic [7:0]  wr_data_i = 0;
    logic [4:0]  wr_addr_i = 0, rd_addr_o;
    int          n_fail = 0, compares = 0;
    always #25 clk_i = ~clk_i;
    btsd_core dut_u (
        .clk_i         (clk_i),
        .nrst_i        (nrst_i),
        .fetch_word_i  (fetch_word_i),
        .fetch_valid_i (fetch_valid_i),
        .wr_en_i       (wr_en_i),
        .wr_addr_i     (wr_addr_i),
        .wr_data_i     (wr_data_i),
        .exec_word_o   (exec_word_o),
        .exec_valid_o  (exec_valid_o),
        .skip_o        (skip_o),
        .nop_cycle_o   (nop_cycle_o),
        .flags_we_o    (flags_we_o),
        .rd_addr_o     (rd_addr_o)
    );
    task t_test(input logic [11:0] w, x, input logic s);
        @(negedge clk_i) fetch_word_i = w;
        @(negedge clk_i);
        `CHK(rd_addr_o, w[4:0])
        fetch_word_i = x;
        @(negedge clk_i) fetch_word_i = 12'h2c3;
        `CHK({exec_word_o, skip_o}, {w, s})
        @(negedge clk_i);
        `CHK({exec_valid_o, nop_cycle_o, exec_word_o}, s ? 14'h1000 : {2'b10, x})
        `CHK(skip_o, 1'b0)
        `CHK(flags_we_o, 1'b0)
    endtask
    task sc_slot;
        t_test(12'h75f, 12'h69f, 1'b1);
    endtask
    task sc_invalid;
        @(negedge clk_i) {fetch_valid_i, fetch_word_i} = {1'b0, 12'h7ff};
        @(negedge clk_i) fetch_word_i = 12'h2c3;
        @(negedge clk_i) fetch_valid_i = 1'b1;
        `CHK({exec_valid_o, skip_o, exec_word_o}, {2'b00, 12'h7ff})
    endtask
    task sc_bits(input logic [4:0] f, input logic [7:0] p);
        @(negedge clk_i) {wr_en_i, wr_addr_i, wr_data_i} = {1'b1, f, p};
        @(negedge clk_i) wr_en_i = 0;
        for (int b = 0; b < 8; b++) begin
            t_test({4'h7, b[2:0], f}, 12'h2c3, p[b]);
            t_test({4'h6, b[2:0], f}, 12'h2c3, !p[b]);
        end
    endtask
    task finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        nrst_i = 1;
        sc_bits(5'h00, 8'h3c);
        sc_bits(5'h1f, 8'ha5);
        sc_slot;
        sc_invalid;
        finish_test;
    end
endmodule
